// ==== design/comparator_ref_ladder_ctrl.sv ====
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module comparator_ref_ladder_ctrl
	import cmp_ref_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog comparator results and device state
	input wire logic cmp1_result,
	input wire logic cmp2_result,
	input wire logic sleep_active,
	input wire logic port_a_direction_bit2,
	// Comparator controls
	output logic comparators_powered,
	output logic [2:0] comparator_mode_field,
	output logic comparator_input_switch,
	output logic internal_ref_to_plus,
	// Reference ladder controls
	output logic ladder_power_on,
	output logic ladder_range_low,
	output logic [6:0] ladder_level,
	output logic shared_analog_pin_drive,
	// Interrupt and wake
	output logic irq,
	output logic wake_request
);
	// ==========================================================
	// State
	logic [7:0] cmp_ctrl_q, cmp_ctrl_d;
	logic [7:0] ladder_ctrl_q, ladder_ctrl_d;
	logic [1:0] outputs_seen_q, outputs_seen_d;
	logic change_flag_q, change_flag_d;
	logic change_mask_q, change_mask_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic cmp_on_q, cmp_on_d;
	logic int_ref_q, int_ref_d;
	logic pin_drive_q, pin_drive_d;
	logic irq_q, irq_d;
	logic wake_q, wake_d;
	logic [6:0] level_q;

	// ==========================================================
	// Decode helpers
	logic setup_phase;
	logic access_done;
	logic wr_done;
	logic rd_done;
	logic sel_cmp;
	logic sel_ladder;
	logic sel_status;
	logic sel_mask;
	logic sel_valid;
	logic cmp_active;
	logic [1:0] cmp_outputs;
	logic [7:0] cmp_read;
	logic [7:0] ladder_read;

	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready_q;
	assign wr_done = access_done && pwrite && !pslverr_q;
	assign rd_done = access_done && !pwrite && !pslverr_q;

	// Address decode
	always_comb
	begin
		sel_cmp = 1'b0;
		sel_ladder = 1'b0;
		sel_status = 1'b0;
		sel_mask = 1'b0;
		if (paddr == CMP_CTRL_ADDR)
			sel_cmp = 1'b1;
		else if (paddr == LADDER_CTRL_ADDR)
			sel_ladder = 1'b1;
		else if (paddr == IRQ_STATUS_ADDR)
			sel_status = 1'b1;
		else if (paddr == IRQ_MASK_ADDR)
			sel_mask = 1'b1;
		sel_valid = sel_cmp || sel_ladder || sel_status || sel_mask;
	end

	// ==========================================================
	// Comparator core
	// Modes 000 and 111 keep both comparators unpowered; sleep has no say here,
	// so a running comparator keeps running while the device sleeps
	always_comb
	begin
		cmp_active = (cmp_ctrl_q[2:0] != MODE_RESET) && (cmp_ctrl_q[2:0] != MODE_OFF);
		cmp_outputs[0] = cmp_active && (cmp1_result ^ cmp_ctrl_q[INV1_BIT]);
		cmp_outputs[1] = cmp_active && (cmp2_result ^ cmp_ctrl_q[INV2_BIT]);
		cmp_read = {cmp_outputs[1], cmp_outputs[0], cmp_ctrl_q[5:0]};
		ladder_read = ladder_ctrl_q & LADDER_CTRL_WMASK;
	end

	// Register file next state; no path touches it on sleep or wake
	always_comb
	begin
		cmp_ctrl_d = cmp_ctrl_q;
		ladder_ctrl_d = ladder_ctrl_q;
		change_mask_d = change_mask_q;
		if (wr_done && sel_cmp)
			cmp_ctrl_d = (pwdata[7:0] & CMP_CTRL_WMASK) | (cmp_ctrl_q & ~CMP_CTRL_WMASK);
		if (wr_done && sel_ladder)
			ladder_ctrl_d = pwdata[7:0] & LADDER_CTRL_WMASK;
		if (wr_done && sel_mask)
			change_mask_d = pwdata[CHANGE_FLAG_BIT];
	end

	// Mismatch latch and sticky change flag
	// Any access to the comparator register resyncs the latch, ending the mismatch;
	// a still-present mismatch keeps setting the flag, so the set wins over a clear
	// A status write of one sets the flag by hand, to exercise the interrupt path
	always_comb
	begin
		outputs_seen_d = outputs_seen_q;
		if (access_done && sel_cmp)
			outputs_seen_d = cmp_outputs;
		change_flag_d = change_flag_q;
		if (rd_done && sel_status)
			change_flag_d = 1'b0;
		if (wr_done && sel_status && pwdata[CHANGE_FLAG_BIT])
			change_flag_d = 1'b1;
		if (cmp_outputs != outputs_seen_q)
			change_flag_d = 1'b1;
	end

	// ==========================================================
	// APB answer, computed in setup so the access phase lasts one cycle
	// pslverr holds until the next setup; it only counts while pready is high
	always_comb
	begin
		prdata_d = prdata_q;
		pready_d = setup_phase;
		pslverr_d = pslverr_q;
		if (setup_phase)
		begin
			pslverr_d = !sel_valid;
			prdata_d = 32'h0000_0000;
			if (sel_cmp)
				prdata_d = {24'h00_0000, cmp_read};
			else if (sel_ladder)
				prdata_d = {24'h00_0000, ladder_read};
			else if (sel_status)
				prdata_d = {31'h0000_0000, change_flag_q};
			else if (sel_mask)
				prdata_d = {31'h0000_0000, change_mask_q};
		end
	end

	// ==========================================================
	// Output stage; the ladder path never looks at the comparator mode
	always_comb
	begin
		cmp_on_d = cmp_active;
		int_ref_d = cmp_ctrl_q[2:0] == MODE_INT_REF;
		pin_drive_d = port_a_direction_bit2 && ladder_ctrl_q[LADDER_PIN_OE_BIT];
		// Pin drive also waits for ladder power, so an unpowered ladder never loads the pin
		pin_drive_d = pin_drive_d && ladder_ctrl_q[LADDER_POWER_BIT];
		irq_d = change_flag_d && change_mask_d;
		wake_d = sleep_active && irq_d;
	end

	// All registers
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			cmp_ctrl_q <= CMP_CTRL_RESET;
			ladder_ctrl_q <= LADDER_CTRL_RESET;
			outputs_seen_q <= 2'h0;
			change_flag_q <= 1'b0;
			change_mask_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			cmp_on_q <= 1'b0;
			int_ref_q <= 1'b0;
			pin_drive_q <= 1'b0;
			irq_q <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			cmp_ctrl_q <= cmp_ctrl_d;
			ladder_ctrl_q <= ladder_ctrl_d;
			outputs_seen_q <= outputs_seen_d;
			change_flag_q <= change_flag_d;
			change_mask_q <= change_mask_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			cmp_on_q <= cmp_on_d;
			int_ref_q <= int_ref_d;
			pin_drive_q <= pin_drive_d;
			irq_q <= irq_d;
			wake_q <= wake_d;
		end
	end

	// ==========================================================
	// Ladder level generator, fed only from the ladder register
	ladder_level u_level (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.power_on(ladder_ctrl_q[LADDER_POWER_BIT]),
		.range_low(ladder_ctrl_q[LADDER_RANGE_BIT]),
		.tap(ladder_ctrl_q[TAP_LSB +: TAP_W]),
		.level_q(level_q)
	);

	// Ports
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign comparators_powered = cmp_on_q;
	assign comparator_mode_field = cmp_ctrl_q[MODE_LSB +: 3];
	assign comparator_input_switch = cmp_ctrl_q[INPUT_SWITCH_BIT];
	assign internal_ref_to_plus = int_ref_q;
	assign ladder_power_on = ladder_ctrl_q[LADDER_POWER_BIT];
	assign ladder_range_low = ladder_ctrl_q[LADDER_RANGE_BIT];
	assign ladder_level = level_q;
	assign shared_analog_pin_drive = pin_drive_q;
	assign irq = irq_q;
	assign wake_request = wake_q;

	// ==========================================================
	// Assertions
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_sleep_keeps_running: assert property (
		sleep_active && cmp_active |=> comparators_powered)
		else $error("comparator stopped in sleep");
	a_mode_off_power: assert property (
		cmp_ctrl_q[2:0] == MODE_OFF |-> cmp_read[7:6] == 2'h0 ##1 !comparators_powered)
		else $error("mode off left comparator on");
	a_cmp_hold_sleep: assert property (
		!wr_done |=> $stable(cmp_ctrl_q))
		else $error("comparator control changed without write");
	a_reset_mode_zero: assert property (
		$rose(reset_n) |-> cmp_ctrl_q == CMP_CTRL_RESET && !comparators_powered)
		else $error("comparator reset state wrong");
	a_ladder_reset_clear: assert property (
		$rose(reset_n) |-> ladder_ctrl_q == LADDER_CTRL_RESET && !shared_analog_pin_drive)
		else $error("ladder reset state wrong");
	a_unused_bit_zero: assert property (
		ladder_read[LADDER_UNUSED_BIT] == 1'b0)
		else $error("unused ladder bit reads one");
	a_ladder_hold_wake: assert property (
		$fell(sleep_active) && !wr_done |=> $stable(ladder_ctrl_q))
		else $error("ladder control changed on wake");
	a_pin_needs_both: assert property (
		shared_analog_pin_drive |->
		$past(port_a_direction_bit2) && $past(ladder_ctrl_q[LADDER_PIN_OE_BIT]))
		else $error("pin driven without both enables");
	a_int_ref_route: assert property (
		cmp_ctrl_q[2:0] == MODE_INT_REF |=> internal_ref_to_plus)
		else $error("internal reference not routed");
	a_change_sets_flag: assert property (
		cmp_outputs != outputs_seen_q |=> change_flag_q)
		else $error("output change missed");
	a_flag_sticky: assert property (
		change_flag_q && !(rd_done && sel_status) |=> change_flag_q)
		else $error("change flag dropped");
	a_unpowered_level: assert property (
		!ladder_ctrl_q[LADDER_POWER_BIT] |=> ladder_level == 7'h00)
		else $error("level active while unpowered");
	a_ladder_ignores_mode: assert property (
		wr_done && sel_cmp |=> $stable(ladder_ctrl_q))
		else $error("comparator write touched ladder");
	a_wake_from_irq: assert property (
		sleep_active && irq_d |=> wake_request)
		else $error("no wake on interrupt");

	// Follow-up checks on flag, interrupt, wake, pin drive, reset state, modes and register writes
	a_read_clears_flag: assert property (
		rd_done && sel_status && cmp_outputs == outputs_seen_q |=> !change_flag_q)
		else $error("status read left flag set");
	a_status_write_sets: assert property (
		wr_done && sel_status && pwdata[CHANGE_FLAG_BIT] |=> change_flag_q)
		else $error("status write did not set flag");
	a_irq_level: assert property (
		irq == (change_flag_q && change_mask_q))
		else $error("interrupt level wrong");
	a_mask_blocks_wake: assert property (
		!change_mask_d |=> !wake_request)
		else $error("masked flag woke device");
	a_wake_needs_sleep: assert property (
		wake_request |-> $past(sleep_active))
		else $error("wake without sleep");
	a_wake_keeps_ladder: assert property (
		wake_request && !wr_done |=> $stable(ladder_ctrl_q))
		else $error("ladder control changed while waking");
	a_unpowered_no_pin: assert property (
		!ladder_ctrl_q[LADDER_POWER_BIT] |=> !shared_analog_pin_drive)
		else $error("unpowered ladder drives pin");
	a_reset_level_off: assert property (
		$rose(reset_n) |-> ladder_level == 7'h00 && !ladder_power_on && !irq)
		else $error("reference active after reset");
	a_reset_mode_inputs: assert property (
		cmp_ctrl_q[2:0] == MODE_RESET |-> cmp_read[7:6] == 2'h0)
		else $error("reset mode shows comparator output");
	a_int_ref_only_mode: assert property (
		cmp_ctrl_q[2:0] != MODE_INT_REF |=> !internal_ref_to_plus)
		else $error("internal reference routed in wrong mode");
	a_ladder_power_write: assert property (
		wr_done && sel_ladder |=> ladder_power_on == $past(pwdata[LADDER_POWER_BIT]))
		else $error("ladder power write lost");
	a_ladder_range_write: assert property (
		wr_done && sel_ladder |=> ladder_range_low == $past(pwdata[LADDER_RANGE_BIT]))
		else $error("ladder range write lost");
	a_mode_write_lands: assert property (
		wr_done && sel_cmp |=> comparator_mode_field == $past(pwdata[2:0]))
		else $error("comparator mode write lost");

	c_wake_seen: cover property (sleep_active ##1 wake_request);
	c_int_ref_mode: cover property (wr_done && sel_cmp ##2 internal_ref_to_plus);
	c_pin_drive: cover property ($rose(shared_analog_pin_drive));
	c_flag_clear: cover property (change_flag_q ##1 rd_done && sel_status ##1 !change_flag_q);
	c_low_range_tap: cover property (ladder_power_on && ladder_range_low ##2 ladder_level != 7'h00);
endmodule : comparator_ref_ladder_ctrl

// ==== design/cmp_ref_pkg.sv ====
// ==========================================================
// Register map, field layout and scaling constants
package cmp_ref_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] CMP_CTRL_IDX = 8'h1F;
	localparam logic [7:0] LADDER_CTRL_IDX = 8'h9F;
	localparam logic [7:0] IRQ_STATUS_IDX = 8'hA0;
	localparam logic [7:0] IRQ_MASK_IDX = 8'hA1;
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] CMP_CTRL_ADDR = {2'h0, CMP_CTRL_IDX, 2'h0};
	localparam logic [11:0] LADDER_CTRL_ADDR = {2'h0, LADDER_CTRL_IDX, 2'h0};
	localparam logic [11:0] IRQ_STATUS_ADDR = {2'h0, IRQ_STATUS_IDX, 2'h0};
	localparam logic [11:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};
	// Reset values and writable bits
	localparam logic [7:0] CMP_CTRL_RESET = 8'h00;
	localparam logic [7:0] LADDER_CTRL_RESET = 8'h00;
	localparam logic [7:0] CMP_CTRL_WMASK = 8'h3F;
	localparam logic [7:0] LADDER_CTRL_WMASK = 8'hEF;
	// Comparator control fields
	localparam int unsigned MODE_LSB = 0;
	localparam int unsigned INPUT_SWITCH_BIT = 3;
	localparam int unsigned INV1_BIT = 4;
	localparam int unsigned INV2_BIT = 5;
	localparam int unsigned OUT1_BIT = 6;
	localparam int unsigned OUT2_BIT = 7;
	// Reference ladder control fields
	localparam int unsigned LADDER_POWER_BIT = 7;
	localparam int unsigned LADDER_PIN_OE_BIT = 6;
	localparam int unsigned LADDER_RANGE_BIT = 5;
	localparam int unsigned LADDER_UNUSED_BIT = 4;
	localparam int unsigned TAP_LSB = 0;
	localparam int unsigned TAP_W = 4;
	// Interrupt status and mask layout
	localparam int unsigned CHANGE_FLAG_BIT = 0;
	// Reference level in units of supply/96 so both ranges are exact
	localparam int unsigned LEVEL_W = 7;
	localparam int unsigned LEVEL_SCALE = 96;
	localparam int unsigned LOW_DIV = 24;
	localparam int unsigned HIGH_DIV = 32;
	localparam logic [6:0] LOW_STEP = 7'(LEVEL_SCALE / LOW_DIV);
	localparam logic [6:0] HIGH_STEP = 7'(LEVEL_SCALE / HIGH_DIV);
	localparam logic [6:0] HIGH_BASE = 7'(LEVEL_SCALE / 4);
	// Comparator operating modes
	typedef enum logic [2:0] {
		MODE_RESET = 3'b000,
		MODE_MUX_ONE = 3'b001,
		MODE_INT_REF = 3'b010,
		MODE_FOUR_IN = 3'b011,
		MODE_TWO_COMMON = 3'b100,
		MODE_TWO_IND = 3'b101,
		MODE_TWO_OUT = 3'b110,
		MODE_OFF = 3'b111
	} comparator_mode_e;
endpackage : cmp_ref_pkg

// ==== design/ladder_level.sv ====
`timescale 1ns/1ns
// ==========================================================
// Tap to reference level, in units of supply/96
module ladder_level
	import cmp_ref_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Ladder settings
	input wire logic power_on,
	input wire logic range_low,
	input wire logic [3:0] tap,
	// Level
	output logic [6:0] level_q
);
	logic [6:0] level_d;

	// Low range tap/24, high range 1/4 + tap/32, zero while unpowered
	always_comb
	begin
		if (!power_on)
			level_d = 7'h00;
		else if (range_low)
			level_d = 7'(LOW_STEP * {3'h0, tap});
		else
			level_d = 7'(HIGH_BASE + HIGH_STEP * {3'h0, tap});
	end

	// Level register
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			level_q <= 7'h00;
		else
			level_q <= level_d;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_low_range_level: assert property (
		power_on && range_low |=> level_q == 7'(4 * $past(tap)))
		else $error("low range level wrong");
	a_high_range_level: assert property (
		power_on && !range_low |=> level_q == 7'(24 + 3 * $past(tap)))
		else $error("high range level wrong");
endmodule : ladder_level

// ==== sim/comparator_ref_ladder_ctrl_test.sv ====
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the comparator and reference ladder control
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module comparator_ref_ladder_ctrl_test
	import cmp_ref_pkg::*;
;
	// Bench-driven inputs, all defined at time zero
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic cmp1_result = 1'b0;
	logic cmp2_result = 1'b0;
	logic sleep_active = 1'b0;
	logic port_a_direction_bit2 = 1'b0;
	// Design outputs
	logic [31:0] prdata;
	logic pready, pslverr, comparators_powered, comparator_input_switch, internal_ref_to_plus;
	logic [2:0] comparator_mode_field;
	logic ladder_power_on, ladder_range_low, shared_analog_pin_drive, irq, wake_request;
	logic [6:0] ladder_level;
	// Bookkeeping
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] rd;
	logic er;

	comparator_ref_ladder_ctrl dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp1_result(cmp1_result),
		.cmp2_result(cmp2_result), .sleep_active(sleep_active),
		.port_a_direction_bit2(port_a_direction_bit2),
		.comparators_powered(comparators_powered), .comparator_mode_field(comparator_mode_field),
		.comparator_input_switch(comparator_input_switch),
		.internal_ref_to_plus(internal_ref_to_plus), .ladder_power_on(ladder_power_on),
		.ladder_range_low(ladder_range_low), .ladder_level(ladder_level),
		.shared_analog_pin_drive(shared_analog_pin_drive), .irq(irq),
		.wake_request(wake_request));

	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	// ==========================================================
	// Run control
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// Hang guard; the whole sequence needs well under 3000 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// APB master; holds the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read a register and compare its byte
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		`CHK(rd, e)
		`CHK(er, 1'b0)
	endtask : rchk

	// Derived outputs lag the register by one edge; sample clear of the edge
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : settle

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		`CHK(comparator_mode_field, 3'h0)
		`CHK(comparators_powered, 1'b0)
		`CHK(ladder_power_on, 1'b0)
		`CHK(ladder_level, 7'h00)
		rchk(CMP_CTRL_ADDR, 8'h00);
		rchk(LADDER_CTRL_ADDR, 8'h00);
	endtask : t_reset

	// Every tap in both ranges; level counted in supply/96 steps
	task automatic t_ladder();
		logic [6:0] e;
		for (int r = 0; r < 2; r++)
			for (int t = 0; t < 16; t++)
			begin
				apb(1'b1, LADDER_CTRL_ADDR, {1'b1, 1'b0, r[0], 1'b1, t[3:0]});
				settle();
				e = r ? 7'(t * 4) : 7'(24 + t * 3);
				`CHK(ladder_level, e)
				`CHK(ladder_range_low, r[0])
				`CHK(ladder_power_on, 1'b1)
				rchk(LADDER_CTRL_ADDR, {1'b1, 1'b0, r[0], 1'b0, t[3:0]});
			end
		apb(1'b1, LADDER_CTRL_ADDR, 8'h6F);
		settle();
		`CHK(ladder_power_on, 1'b0)
		`CHK(ladder_level, 7'h00)
	endtask : t_ladder

	// All combinations of direction, pin enable and power
	task automatic t_pin();
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, LADDER_CTRL_ADDR, {i[0], i[1], 6'h00});
			port_a_direction_bit2 <= i[2];
			settle();
			`CHK(shared_analog_pin_drive, &i[2:0])
		end
	endtask : t_pin

	// Every mode; read-only output bits written as ones must not stick
	task automatic t_modes();
		apb(1'b1, LADDER_CTRL_ADDR, 8'hA6);
		for (int m = 0; m < 8; m++)
		begin
			apb(1'b1, CMP_CTRL_ADDR, {4'hC, m[0], m[2:0]});
			settle();
			`CHK(comparators_powered, (m != 0 && m != 7))
			`CHK(internal_ref_to_plus, (m == 2))
			`CHK(comparator_mode_field, m[2:0])
			`CHK(comparator_input_switch, m[0])
			`CHK(ladder_level, 7'h18)
			rchk(CMP_CTRL_ADDR, {4'h0, m[0], m[2:0]});
		end
	endtask : t_modes

	// Change flag, sticky clear, masking and wake from sleep
	task automatic t_irq();
		apb(1'b1, CMP_CTRL_ADDR, 8'h02);
		apb(1'b1, IRQ_MASK_ADDR, 8'h01);
		rchk(IRQ_STATUS_ADDR, 8'h00);
		cmp1_result <= 1'b1;
		settle();
		`CHK(irq, 1'b1)
		rchk(IRQ_STATUS_ADDR, 8'h01);
		rchk(IRQ_STATUS_ADDR, 8'h01);
		rchk(CMP_CTRL_ADDR, 8'h42);
		rchk(IRQ_STATUS_ADDR, 8'h01);
		rchk(IRQ_STATUS_ADDR, 8'h00);
		settle();
		`CHK(irq, 1'b0)
		apb(1'b1, LADDER_CTRL_ADDR, 8'h26);
		sleep_active <= 1'b1;
		apb(1'b1, IRQ_STATUS_ADDR, 8'h01);
		settle();
		`CHK(wake_request, 1'b1)
		`CHK(comparators_powered, 1'b1)
		`CHK(ladder_level, 7'h00)
		rchk(CMP_CTRL_ADDR, 8'h42);
		rchk(LADDER_CTRL_ADDR, 8'h26);
		apb(1'b1, IRQ_MASK_ADDR, 8'h00);
		settle();
		`CHK(irq, 1'b0)
		`CHK(wake_request, 1'b0)
		@(posedge ref_clk);
		sleep_active <= 1'b0;
		rchk(IRQ_STATUS_ADDR, 8'h01);
		rchk(LADDER_CTRL_ADDR, 8'h26);
	endtask : t_irq

	// Unmapped place refused, then a reset in mid-run
	task automatic t_refuse_reset();
		apb(1'b1, 12'h400, 8'hFF);
		`CHK(er, 1'b1)
		apb(1'b0, 12'h400, 8'h00);
		`CHK(er, 1'b1)
		`CHK(rd, 8'h00)
		rchk(LADDER_CTRL_ADDR, 8'h26);
		apb(1'b1, CMP_CTRL_ADDR, 8'h05);
		reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		t_reset();
	endtask : t_refuse_reset

	// Main sequence
	initial
	begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		t_reset();
		t_ladder();
		t_pin();
		t_modes();
		t_irq();
		t_refuse_reset();
		tally_and_finish();
	end
endmodule : comparator_ref_ladder_ctrl_test
